// ### ebc_slave.sv
`timescale 1ns/1ps
// Operation
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop, ends sequence
// - Stop after read returns to standby
// - Transfers are 8-bit words, bit per clock
// - Device acks each word in ninth cycle; a received word that meets a full buffer gets no ack
// - Standby at power-up and after stop, except a complete write: standby after its write cycle
// - Sample on rising, shift on falling edge
// - Address match acks; mismatch returns standby
// - Write cycle ignores inputs, no ack
module ebc_slave
  import ebc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = EBC_WRITE_CYCLES,
  parameter int unsigned FIFO_DEPTH   = 4
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  // Bus pins
  input  wire logic         i_scl,
  input  wire logic         i_sda,
  output logic              o_sda_out,
  output logic              o_sda_oe_n,
  // Address strap pins
  input  wire logic [2:0]   i_dev_sel,
  // Received words
  output logic              o_rx_valid,
  output ebc_rx_word_t      o_rx_word,
  input  wire logic         i_rx_ready,
  // Words to send
  input  wire logic [7:0]   i_tx_data,
  output logic              o_tx_req,
  // Status
  output logic              o_standby,
  output logic              o_write_busy,
  output logic              o_start,
  output logic              o_stop
);

  localparam int unsigned BW = $clog2(WRITE_CYCLES + 1);

  if (WRITE_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("ebc_slave needs WRITE_CYCLES >= 1 and FIFO_DEPTH >= 2");
  end

  ebc_pins_t    s1, s2, s3, pin, pin_d, next_pin;
  ebc_state_t   state, next_state;
  logic [2:0]   cnt, next_cnt;
  logic [7:0]   sh, next_sh, rx_byte;
  logic [1:0]   bytes, next_bytes;
  logic [BW-1:0] busy_cnt, next_busy_cnt;
  logic         rw, next_rw, ack_on, next_ack_on, ack_ok, next_ack_ok;
  logic         first, next_first, oe_n, next_oe_n, push, next_push;
  logic         tx_req, next_tx_req, standby, busy, start_p, stop_p;
  logic         sda_low, load, fifo_ready;
  logic         scl_rise, scl_fall, ev_start, ev_stop;
  ebc_rx_word_t push_word, next_push_word;

  // Device type and strap compare of an address word
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [2:0] sel);
    return (b[7:4] == EBC_DEV_TYPE) && (b[3:1] == sel);
  endfunction : addr_match

  // Pin filter: a level counts once stages two and three agree
  always_comb begin
    next_pin = ebc_pins_t'((s2 & s3) | (pin & (s2 | s3)));
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1    <= EBC_PINS_IDLE;
      s2    <= EBC_PINS_IDLE;
      s3    <= EBC_PINS_IDLE;
      pin   <= EBC_PINS_IDLE;
      pin_d <= EBC_PINS_IDLE;
    end else begin
      s1    <= '{sel: i_dev_sel, sda: i_sda, scl: i_scl};
      s2    <= s1;
      s3    <= s2;
      pin   <= next_pin;
      pin_d <= pin;
    end
  end

  // Clock edges and bus conditions
  assign scl_rise = pin.scl & ~pin_d.scl;
  assign scl_fall = ~pin.scl & pin_d.scl;
  assign ev_start = pin.scl & pin_d.scl & pin_d.sda & ~pin.sda;
  assign ev_stop  = pin.scl & pin_d.scl & ~pin_d.sda & pin.sda;

  // Transfer controller next values
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_sh        = sh;
    next_bytes     = bytes;
    next_busy_cnt  = busy_cnt;
    next_rw        = rw;
    next_ack_on    = ack_on;
    next_ack_ok    = ack_ok;
    next_first     = first;
    next_oe_n      = oe_n;
    next_push      = 1'b0;
    next_push_word = push_word;
    next_tx_req    = 1'b0;
    load           = 1'b0;
    rx_byte        = {sh[6:0], pin.sda};
    unique case (state)
      ST_IDLE: begin
      end
      ST_ADDR: begin
        if (scl_rise) begin
          next_sh  = rx_byte;
          next_cnt = cnt + 3'h1;
          if (cnt == EBC_LAST_BIT) begin
            if (addr_match(rx_byte, pin.sel)) begin
              next_state  = ST_ACK;
              next_ack_ok = 1'b1;
              next_rw     = rx_byte[0];
              next_first  = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          next_sh  = rx_byte;
          next_cnt = cnt + 3'h1;
          if (cnt == EBC_LAST_BIT) begin
            next_state     = ST_ACK;
            next_ack_ok    = fifo_ready;
            next_push      = fifo_ready;
            next_push_word = '{first: first, data: rx_byte};
            next_first     = first & ~fifo_ready;
            if (fifo_ready && bytes != EBC_BYTES_FULL) begin
              next_bytes = bytes + 2'h1;
            end
          end
        end
      end
      ST_ACK: begin
        if (scl_fall && !ack_on) begin
          next_ack_on = 1'b1;
          next_oe_n   = ~ack_ok;
        end else if (scl_fall) begin
          next_ack_on = 1'b0;
          next_oe_n   = 1'b1;
          load        = rw;
          next_state  = rw ? ST_TX : ST_RX;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          next_oe_n = sh[7];
          next_sh   = {sh[6:0], 1'b0};
        end
        if (scl_rise) begin
          next_cnt = cnt + 3'h1;
          if (cnt == EBC_LAST_BIT) begin
            next_state = ST_TXACK;
          end
        end
      end
      ST_TXACK: begin
        if (scl_fall) begin
          next_oe_n = 1'b1;
        end
        if (scl_rise) begin
          next_state = pin.sda ? ST_IDLE : ST_TXNEXT;
        end
      end
      ST_TXNEXT: begin
        load = scl_fall;
      end
      ST_WBUSY: begin
        next_busy_cnt = busy_cnt - BW'(1);
        if (busy_cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
    endcase
    // First data bit goes out on the falling edge
    if (load) begin
      next_state  = ST_TX;
      next_oe_n   = i_tx_data[7];
      next_sh     = {i_tx_data[6:0], 1'b0};
      next_cnt    = '0;
      next_tx_req = 1'b1;
    end
    // Stop ends any sequence; a complete write starts the cycle
    if (state != ST_WBUSY && ev_stop) begin
      next_state    = (bytes == EBC_BYTES_FULL) ? ST_WBUSY : ST_IDLE;
      next_busy_cnt = BW'(WRITE_CYCLES - 1);
      next_oe_n     = 1'b1;
      next_ack_on   = 1'b0;
    end
    // Start restarts address reception in every state but the write cycle, even mid-word
    if (state != ST_WBUSY && ev_start) begin
      next_state  = ST_ADDR;
      next_cnt    = '0;
      next_bytes  = '0;
      next_oe_n   = 1'b1;
      next_ack_on = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      sh        <= '0;
      bytes     <= '0;
      busy_cnt  <= '0;
      rw        <= 1'b0;
      ack_on    <= 1'b0;
      ack_ok    <= 1'b0;
      first     <= 1'b0;
      oe_n      <= 1'b1;
      push      <= 1'b0;
      push_word <= '0;
      tx_req    <= 1'b0;
      standby   <= 1'b1;
      busy      <= 1'b0;
      start_p   <= 1'b0;
      stop_p    <= 1'b0;
      sda_low   <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      bytes     <= next_bytes;
      busy_cnt  <= next_busy_cnt;
      rw        <= next_rw;
      ack_on    <= next_ack_on;
      ack_ok    <= next_ack_ok;
      first     <= next_first;
      oe_n      <= next_oe_n;
      push      <= next_push;
      push_word <= next_push_word;
      tx_req    <= next_tx_req;
      standby   <= (next_state == ST_IDLE);
      busy      <= (next_state == ST_WBUSY);
      start_p   <= ev_start & (state != ST_WBUSY);
      stop_p    <= ev_stop & (state != ST_WBUSY);
      sda_low   <= 1'b0;
    end
  end

  // Word buffer toward the user side; full buffer refuses the ack
  ebc_fifo #(
    .WIDTH ($bits(ebc_rx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .i_in_data   (push_word),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_word),
    .i_out_ready (i_rx_ready)
  );

  assign o_sda_out    = sda_low;
  assign o_sda_oe_n   = oe_n;
  assign o_tx_req     = tx_req;
  assign o_standby    = standby;
  assign o_write_busy = busy;
  assign o_start      = start_p;
  assign o_stop       = stop_p;

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  start_addr_a: assert property (ev_start && state != ST_WBUSY
    |=> state == ST_ADDR && cnt == '0 ##0 o_start)
    else $error("start not taken");
  restart_a: assert property (ev_start && state inside {ST_ADDR, ST_RX}
    |=> state == ST_ADDR && o_sda_oe_n)
    else $error("start mid word not restarting");
  stop_idle_a: assert property (ev_stop && state != ST_WBUSY
    && bytes != EBC_BYTES_FULL |=> o_standby && o_sda_oe_n)
    else $error("stop did not end sequence");
  read_stop_a: assert property (ev_stop && rw
    && state != ST_WBUSY |=> o_standby)
    else $error("read stop not standby");
  edge_only_a: assert property ($fell(o_sda_oe_n)
    |-> $past(scl_fall))
    else $error("data driven outside clock low");
  ack_drive_a: assert property (state == ST_ACK && scl_fall
    && !ack_on |=> ack_on && o_sda_oe_n == !ack_ok)
    else $error("missing ninth cycle ack");
  full_nack_a: assert property (state == ST_RX && scl_rise
    && cnt == EBC_LAST_BIT |=> ack_ok == $past(fifo_ready))
    else $error("ack not matching buffer room");
  nomatch_a: assert property (state == ST_ADDR && scl_rise
    && cnt == EBC_LAST_BIT && !addr_match(rx_byte, pin.sel)
    |=> o_standby ##1 o_sda_oe_n)
    else $error("mismatch not dropped");
  busy_quiet_a: assert property (o_write_busy
    |-> o_sda_oe_n && !o_start && !o_tx_req)
    else $error("driving during write cycle");
  busy_end_a: assert property (state == ST_WBUSY && busy_cnt == '0
    |=> o_standby && !o_write_busy)
    else $error("write cycle not ending in standby");
  word_len_a: assert property (push |-> $past(state) == ST_RX
    && $past(cnt) == EBC_LAST_BIT && $past(scl_rise))
    else $error("word pushed off the eighth bit");
  sample_a: assert property (state == ST_ADDR && scl_rise
    |=> sh[0] == $past(pin.sda))
    else $error("bit not sampled on rising edge");
  power_up_a: assert property ($past(i_rst) |-> o_standby)
    else $error("not standby after reset");

  addr_ack_c: cover property (state == ST_ACK && ack_ok && !o_sda_oe_n);
  read_c:     cover property (o_tx_req ##[1:1000] state == ST_TXACK);
  write_c:    cover property ($rose(o_write_busy));
  nack_c:     cover property (state == ST_ACK && !ack_ok && ack_on);

endmodule : ebc_slave

// ### ebc_pkg.sv
package ebc_pkg;

  // Word size and the fixed device type code in the address word
  localparam int unsigned EBC_WORD_BITS   = 8;
  localparam logic [3:0]  EBC_DEV_TYPE    = 4'ha;

  // Core clock rate and the self-timed write cycle
  localparam int unsigned EBC_CLK_MHZ       = 40;
  localparam int unsigned EBC_WRITE_TIME_US = 5000;
  localparam int unsigned EBC_WRITE_CYCLES  =
    EBC_WRITE_TIME_US * EBC_CLK_MHZ;

  // Word address bytes that precede data in a write sequence
  localparam int unsigned EBC_ADDR_BYTES = 2;
  localparam logic [1:0]  EBC_BYTES_FULL = 2'h3;

  // Bit counter value of the last bit of a word
  localparam logic [2:0]  EBC_LAST_BIT = 3'h7;

  // Controller states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ADDR   = 8'h02,
    ST_ACK    = 8'h04,
    ST_RX     = 8'h08,
    ST_TX     = 8'h10,
    ST_TXACK  = 8'h20,
    ST_TXNEXT = 8'h40,
    ST_WBUSY  = 8'h80
  } ebc_state_t;

  // Received word with a flag for the first word after the address
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } ebc_rx_word_t;

  // Pin levels as sampled by the core clock
  typedef struct packed {
    logic [2:0] sel;
    logic       sda;
    logic       scl;
  } ebc_pins_t;

  localparam ebc_pins_t EBC_PINS_IDLE = '{sel: 3'h0, sda: 1'b1, scl: 1'b1};

endpackage : ebc_pkg

// ### ebc_fifo.sv
`timescale 1ns/1ps
module ebc_fifo
  import ebc_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // Filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("ebc_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0]    count, next_count;
  logic             in_ready, out_valid, next_in_ready, next_out_valid;
  logic             push, pop;

  // Pointer advance with wrap at the depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  // Next pointers, count and flags
  always_comb begin
    push           = i_in_valid & in_ready;
    pop            = out_valid & i_out_ready;
    next_mem       = mem;
    next_wr_ptr    = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr    = pop ? bump(rd_ptr) : rd_ptr;
    next_count     = count + CW'(push) - CW'(pop);
    next_in_ready  = (next_count != CW'(DEPTH));
    next_out_valid = (next_count != '0);
    if (push) begin
      next_mem[wr_ptr] = i_in_data;
    end
  end

  // State registers
  always_ff @(posedge i_core_clk) begin
    mem <= next_mem;
    if (i_rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  assign o_in_ready  = in_ready;
  assign o_out_valid = out_valid;
  assign o_out_data  = mem[rd_ptr];

endmodule : ebc_fifo

// ### ebc_master.sv
`timescale 1ns/1ps
module ebc_master #(
  parameter int Q        = 25,
  parameter int BUS_FREE = 52
) (
  // Core clock as time base
  input  wire logic i_core_clk,
  // Bus wires
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Idle bus: clock high, data released
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Wait whole core cycles
  task automatic hold(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : hold

  // One quarter of a bus clock period
  task automatic step(input logic c, input logic d);
    @(posedge i_core_clk) begin
      o_scl     <= c;
      o_sda_low <= d;
    end
    hold(Q);
  endtask : step

  // Data falls while clock high
  task automatic start();
    step(o_scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start

  // Data rises while clock high, then bus left idle
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    hold(BUS_FREE);
  endtask : stop

  // Data set in clock low, read in clock high
  task automatic clk_bit(input logic b, output logic r);
    step(1'b0, !b);
    step(1'b1, !b);
    r = i_sda;
    step(1'b1, !b);
    step(1'b0, !b);
  endtask : clk_bit

  // Eight bits MSB first, then the ninth clock
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], rd[i]);
    clk_bit(mack, ack);
  endtask : xfer

  // Clock until data seen high, then start
  task automatic recover();
    logic r;
    r = 1'b0;
    for (int i = 0; i < 9 && r !== 1'b1; i++) clk_bit(1'b1, r);
    start();
  endtask : recover
endmodule : ebc_master

// ### test_ebc_slave.sv
`timescale 1ns/1ps
module test_ebc_slave;
  import ebc_pkg::*;

  localparam int WCYC = 2000;

  // Design side
  logic         core_clk;
  logic         rst        = 1'b1;
  logic [2:0]   sel        = 3'h5;
  logic         rx_ready   = 1'b0;
  logic [7:0]   tx_data    = 8'h00;
  logic         sda_out;
  logic         sda_oe_n;
  logic         rx_valid;
  ebc_rx_word_t rx_word;
  logic         tx_req;
  logic         standby;
  logic         write_busy;
  logic         start_p;
  logic         stop_p;
  // Bus wires, data pulled up
  logic         scl;
  logic         m_low;
  wire          sda = (m_low | !sda_oe_n) ? 1'b0 : 1'b1;
  // Tallies
  int           n_fail = 0, num_checks = 0;
  int           n_start = 0, n_stop = 0, n_req = 0;
  logic [7:0]   rd;
  logic         ack;

  ebc_slave #(.WRITE_CYCLES(WCYC), .FIFO_DEPTH(4)) ebc_slave_i (
    .i_core_clk(core_clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_dev_sel(sel),
    .o_rx_valid(rx_valid), .o_rx_word(rx_word), .i_rx_ready(rx_ready),
    .i_tx_data(tx_data), .o_tx_req(tx_req), .o_standby(standby),
    .o_write_busy(write_busy), .o_start(start_p), .o_stop(stop_p));

  ebc_master ebc_master_i (
    .i_core_clk(core_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Pulse tallies
  always @(posedge core_clk) begin
    if (start_p === 1'b1) n_start++;
    if (stop_p === 1'b1) n_stop++;
    if (tx_req === 1'b1) n_req++;
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Master sends a byte and judges the device answer
  task automatic wb(input logic [7:0] d, input logic exp);
    ebc_master_i.xfer(d, 1'b1, rd, ack);
    chk({8'h00, ack}, {8'h00, exp});
  endtask : wb

  function automatic logic [7:0] adr(input logic [2:0] s, input logic rw);
    return {EBC_DEV_TYPE, s, rw};
  endfunction : adr

  // Take one word from the receive buffer
  task automatic drain(input logic [8:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk(rx_word, exp);
    @(posedge core_clk) rx_ready <= 1'b1;
    @(posedge core_clk) rx_ready <= 1'b0;
    @(posedge core_clk);
  endtask : drain

  task automatic t_reset();
    chk({7'h00, standby, sda_oe_n}, 9'h003);
    chk({7'h00, write_busy, rx_valid}, 9'h000);
    chk({8'h00, sda_out}, 9'h000);
  endtask : t_reset

  // Fill buffer to refusal, stop, poll while busy, then drain
  task automatic t_write();
    int s0, p0, n;
    s0 = n_start;
    p0 = n_stop;
    ebc_master_i.start();
    wb(adr(sel, 1'b0), 1'b0);
    chk({8'h00, standby}, 9'h000);
    for (int i = 0; i < 4; i++) wb(8'(8'h30 + i), 1'b0);
    wb(8'hee, 1'b1);
    ebc_master_i.stop();
    chk({8'h00, write_busy}, 9'h001);
    ebc_master_i.start();
    wb(adr(sel, 1'b0), 1'b1);
    ebc_master_i.stop();
    chk(9'(n_start - s0), 9'h001);
    chk(9'(n_stop - p0), 9'h001);
    n = 0;
    while (write_busy !== 1'b0 && n < WCYC + 200) begin
      @(posedge core_clk);
      n++;
    end
    ebc_master_i.hold(2);
    chk({8'h00, standby}, 9'h001);
    drain({1'b1, 8'h30});
    for (int i = 1; i < 4; i++) drain({1'b0, 8'(8'h30 + i)});
  endtask : t_write

  task automatic t_nomatch();
    ebc_master_i.start();
    wb(adr(sel ^ 3'h1, 1'b0), 1'b1);
    chk({8'h00, standby}, 9'h001);
    wb(8'h55, 1'b1);
    ebc_master_i.stop();
    chk({8'h00, rx_valid}, 9'h000);
  endtask : t_nomatch

  task automatic t_read();
    int r0;
    r0 = n_req;
    @(posedge core_clk) tx_data <= 8'hc3;
    ebc_master_i.start();
    wb(adr(sel, 1'b1), 1'b0);
    @(posedge core_clk) tx_data <= 8'h5a;
    ebc_master_i.xfer(8'hff, 1'b0, rd, ack);
    chk({1'b0, rd}, 9'h0c3);
    ebc_master_i.xfer(8'hff, 1'b1, rd, ack);
    chk({1'b0, rd}, 9'h05a);
    ebc_master_i.stop();
    chk({8'h00, standby}, 9'h001);
    chk(9'(n_req - r0), 9'h002);
  endtask : t_read

  // Second start after half an address word
  task automatic t_restart();
    logic r;
    ebc_master_i.start();
    for (int i = 7; i > 3; i--) ebc_master_i.clk_bit(i[0], r);
    ebc_master_i.start();
    wb(adr(sel, 1'b0), 1'b0);
    ebc_master_i.stop();
    chk({8'h00, standby}, 9'h001);
  endtask : t_restart

  // Read cut short while device holds data low
  task automatic t_recover();
    logic r;
    @(posedge core_clk) tx_data <= 8'h00;
    ebc_master_i.start();
    wb(adr(sel, 1'b1), 1'b0);
    ebc_master_i.clk_bit(1'b1, r);
    chk({8'h00, r}, 9'h000);
    ebc_master_i.recover();
    wb(adr(sel, 1'b0), 1'b0);
    ebc_master_i.stop();
    chk({8'h00, standby}, 9'h001);
  endtask : t_recover

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    ebc_master_i.hold(4);
    t_reset();
    t_write();
    t_nomatch();
    t_read();
    t_restart();
    t_recover();
    stop_test();
  end
endmodule : test_ebc_slave
